// ---- sim/clock_mode_select_bench.sv ----
// Self-checking bench for the clock mode selection block.
`timescale 1ns/1ps
`default_nettype none
module clock_mode_select_bench;
  logic        clock_in = 1'b0;
  logic        rst_in   = 1'b1;
  logic [2:0]  strap    = 3'h0;
  logic        dual     = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [2:0]  hsize    = 3'h0;
  logic [31:0] hwdata   = 32'h0;
  logic [31:0] hrdata;
  logic        hrdy;
  logic        hresp;
  logic [2:0]  cmode;
  logic        pa, pb, oe, rfp, xs, pr, pl, pg, inv;
  logic [3:0]  fr;
  wire  [2:0]  pins;
  wire         dp;
  logic [31:0] rd;
  int          fail_count  = 0;
  int          check_count = 0;
  logic [7:0]  init_tab [0:6] = '{8'h00, 8'h00, 8'h40, 8'h60, 8'hA6, 8'hA6, 8'hE0};

  always #25 clock_in = ~clock_in;

  cms_strap_model strap_u (.clock_in(clock_in), .strap_in(strap), .dual_in(dual),
    .mode_pins_out(pins), .dual_out(dp));

  cms_clock_mode_select dut_u (.clock_in(clock_in), .rst_in(rst_in),
    .mode_sel_bit2_in(pins[2]), .mode_sel_bit1_in(pins[1]), .mode_sel_bit0_in(pins[0]),
    .pause_req_or_crystal_sel_in(dp), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .clock_mode_out(cmode), .pll_a_run_out(pa), .pll_b_run_out(pb),
    .bidir_clock_pin_oe_out(oe), .ref_from_pin_out(rfp), .crystal_sel_out(xs),
    .pause_req_out(pr), .phase_lead_out(pl), .phase_lag_out(pg),
    .freq_ratio_out(fr), .mode_invalid_out(inv));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Bounded wait for the slave's ready at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (hrdy !== 1'b1) begin
      fail_count++;
      final_report();
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= cms_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= cms_pkg::HSIZE_WORD;
    wait_ready();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk("hresp", hresp, 32'h0);
  endtask

  // Write, then let the register reach the outputs
  task automatic wr_settle(input logic [31:0] addr, input logic [31:0] wd);
    bus(1'b1, addr, wd);
    repeat (2) @(posedge clock_in);
  endtask

  task automatic boot(input logic [2:0] m, input logic d);
    strap  <= m;
    dual   <= d;
    rst_in <= 1'b1;
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clock_in);
  endtask

  // Every legal strap: plan outputs, reset value, forced bits, frequency field
  task automatic mode_scan();
    for (int m = 0; m < 7; m++) begin
      boot(m[2:0], m[0]);
      chk("mode", cmode, m);
      chk("pll_a", pa, m < 2 || m == 4 || m == 5);
      chk("pll_b", pb, m < 4);
      chk("pin_oe", oe, m < 3);
      chk("ref_pin", rfp, m > 3);
      chk("crystal", xs, m < 4 && m[0]);
      chk("pause", pr, m > 3 && m[0]);
      chk("lead", pl, m == 1);
      chk("lag", pg, m == 5);
      chk("fr_init", fr, init_tab[m][3:0]);
      bus(1'b0, 32'h0, 32'h0);
      chk("fmr_init", rd, init_tab[m]);
      wr_settle(32'h0, 32'h1F);
      bus(1'b0, 32'h0, 32'h0);
      chk("fmr_wr", rd, (init_tab[m] & 8'hF0) | 8'h0F);
      chk("fr_out", fr, 4'hF);
    end
  endtask

  // Mode 0 is the preferred strap for register traffic
  task automatic mode0_controls();
    boot(3'h0, 1'b1);
    wr_settle(32'h0, 32'h63);
    bus(1'b0, 32'h0, 32'h0);
    chk("fmr_63", rd, 32'h63);
    chk("pll_a_off", pa, 1'b0);
    chk("pin_hiz", oe, 1'b0);
    chk("fr_3", fr, 4'h3);
    wr_settle(32'h0, 32'h20);
    bus(1'b0, 32'h0, 32'h0);
    chk("hiz_refused", rd, 32'h0);
    chk("pin_on", oe, 1'b1);
    wr_settle(32'h0, 32'h80);
    chk("pll_b_off", pb, 1'b0);
    wr_settle(32'h8, 32'hFF);
    bus(1'b0, 32'h8, 32'h0);
    chk("unmapped", rd, 32'h0);
    wr_settle(32'h4, 32'h5);
    bus(1'b0, 32'h4, 32'h0);
    chk("status_ro", rd, 32'h0);
    bus(1'b0, 32'h0, 32'h0);
    chk("fmr_keep", rd, 32'h80);
  endtask

  task automatic lead_needs_pll_a();
    boot(3'h1, 1'b0);
    wr_settle(32'h0, 32'h40);
    chk("lead_off", pl, 1'b0);
    boot(3'h5, 1'b0);
    wr_settle(32'h0, 32'h40);
    chk("lag_off", pg, 1'b0);
  endtask

  task automatic bad_strap();
    boot(3'h7, 1'b0);
    chk("invalid", inv, 1'b1);
    bus(1'b0, 32'h4, 32'h0);
    chk("status_7", rd, 32'hF);
  endtask

  initial begin
    mode_scan();
    mode0_controls();
    lead_needs_pll_a();
    bad_strap();
    final_report();
  end
endmodule
`default_nettype wire

// ---- sim/cms_strap_model.sv ----
// Board model: strap resistors on the mode pins and the dual-purpose pin.
`timescale 1ns/1ps
`default_nettype none
module cms_strap_model (
  // Clock and strap settings
  input  wire logic       clock_in,
  input  wire logic [2:0] strap_in,
  input  wire logic       dual_in,
  // Pins toward the device
  output logic [2:0]      mode_pins_out,
  output logic            dual_out
);
  // Straps only move while the device sits in reset
  always_ff @(posedge clock_in) begin
    mode_pins_out <= strap_in;
    dual_out      <= dual_in;
  end
endmodule
`default_nettype wire

// ---- verilog/cms_clock_mode_select.sv ----
// Clock mode selection: latches the mode pins and steers the PLLs and clock pin.
// Contract
// - Mode pins decode as mode 0 to 6
// - Mode 0: both PLLs, pin aligned output
// - Modes 0,1: PLL halts and pin hiz writable
// - Mode 1: pin leads by quarter cycle
// - Quarter shift only while first PLL runs
// - Mode 2: second PLL only, pin output
// - Mode 3: second PLL only, pin hiz
// - Mode 4: first PLL locks to pin
// - Mode 5: first PLL, quarter cycle lag
// - Mode 6: no PLL, pin clock used
// - Modes 0-3: reference from oscillator input
// - Modes 4-6: dual pin is pause request
// - Frequency field writable in every mode
// - Modes 0-3: dual pin picks crystal
// - Bits 7,6 halt PLLs; unavailable read 1
// - Bit 5 pin hiz; modes 4-6 read 1
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cms_clock_mode_select (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // Mode pins and dual-purpose pin
  input  wire logic        mode_sel_bit2_in,
  input  wire logic        mode_sel_bit1_in,
  input  wire logic        mode_sel_bit0_in,
  input  wire logic        pause_req_or_crystal_sel_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Clock plan
  output logic [2:0]       clock_mode_out,
  output logic             pll_a_run_out,
  output logic             pll_b_run_out,
  output logic             bidir_clock_pin_oe_out,
  output logic             ref_from_pin_out,
  output logic             crystal_sel_out,
  output logic             pause_req_out,
  output logic             phase_lead_out,
  output logic             phase_lag_out,
  output logic [3:0]       freq_ratio_out,
  output logic             mode_invalid_out
);

  // Mode latch
  logic       rst_seen;
  logic [2:0] mode;
  logic       mode_ok;
  cms_pkg::cms_plan_s plan;
  logic [7:0] init_val;

  wire logic [2:0] pin_mode = {mode_sel_bit2_in, mode_sel_bit1_in, mode_sel_bit0_in};

  cms_mode_decode u_dec (
    .mode_in  (mode),
    .plan_out (plan),
    .init_out (init_val)
  );

  // Pins are caught on every reset cycle; after release the mode is frozen, so
  // a pin change while running cannot disturb the plan.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mode     <= pin_mode;
      rst_seen <= 1'b1;
    end else begin
      rst_seen <= 1'b0;
    end
  end

  // Register state
  logic       pll_b_halt;
  logic       pll_a_halt;
  logic       pin_hiz;
  logic [3:0] freq;

  // Bus address phase capture
  logic       dp_write;
  logic [7:0] dp_addr;

  wire logic addr_take = hsel_in & hready_in & htrans_in[1];
  wire logic ok_size   = (hsize_in == cms_pkg::HSIZE_WORD);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else begin
      dp_write <= addr_take & hwrite_in & ok_size;
      dp_addr  <= haddr_in[7:0];
    end
  end

  // Offset match shared by the write strobe and the read mux
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  wire logic wr_fmr = dp_write & hit(dp_addr, cms_pkg::FMR_OFFSET);

  // Writable halt bits, gated by what the mode makes available
  wire logic next_b_halt = plan.pll_b_avail ? hwdata_in[cms_pkg::PLL_B_HALT_POS] : 1'b1;
  wire logic next_a_halt = plan.pll_a_avail ? hwdata_in[cms_pkg::PLL_A_HALT_POS] : 1'b1;
  // Hiz is refused while the first PLL would run; the pin keeps driving instead.
  wire logic next_hiz    = ~plan.pin_can_drive ? 1'b1 :
                           (next_a_halt ? hwdata_in[cms_pkg::CLK_PIN_HIZ_POS] : 1'b0);

  always_ff @(posedge clock_in) begin
    if (rst_seen) begin
      pll_b_halt <= init_val[cms_pkg::PLL_B_HALT_POS];
      pll_a_halt <= init_val[cms_pkg::PLL_A_HALT_POS];
      pin_hiz    <= init_val[cms_pkg::CLK_PIN_HIZ_POS];
      freq       <= init_val[cms_pkg::FR_LSB +: cms_pkg::FR_WIDTH];
    end else if (wr_fmr) begin
      pll_b_halt <= next_b_halt;
      pll_a_halt <= next_a_halt;
      pin_hiz    <= next_hiz;
      freq       <= hwdata_in[cms_pkg::FR_LSB +: cms_pkg::FR_WIDTH];
    end
  end

  // Read data mux
  wire logic [7:0] fmr_view = {pll_b_halt, pll_a_halt, pin_hiz, 1'b0, freq};
  wire logic [7:0] stat_view = {4'h0, ~plan.valid, mode};
  // Read data is muxed in the address phase so it stands through the data
  // phase; a write landing on the same edge is forwarded.
  wire logic [7:0] fmr_next_view = {next_b_halt, next_a_halt, next_hiz, 1'b0,
                                    hwdata_in[cms_pkg::FR_LSB +: cms_pkg::FR_WIDTH]};
  wire logic [7:0] fmr_now = wr_fmr ? fmr_next_view : fmr_view;
  wire logic       rd_take = addr_take & ~hwrite_in;
  wire logic [31:0] rd_mux =
      hit(haddr_in[7:0], cms_pkg::FMR_OFFSET)  ? {24'h000000, fmr_now} :
      hit(haddr_in[7:0], cms_pkg::STAT_OFFSET) ? {24'h000000, stat_view} : 32'h00000000;

  // Derived run states
  wire logic a_run = plan.valid & plan.pll_a_avail & ~pll_a_halt;
  wire logic b_run = plan.valid & plan.pll_b_avail & ~pll_b_halt;
  wire logic drive = plan.valid & plan.pin_can_drive & ~pin_hiz;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      hrdata_out             <= 32'h00000000;
      hreadyout_out          <= 1'b1;
      hresp_out              <= 1'b0;
      clock_mode_out         <= 3'h0;
      pll_a_run_out          <= 1'b0;
      pll_b_run_out          <= 1'b0;
      bidir_clock_pin_oe_out <= 1'b0;
      ref_from_pin_out       <= 1'b0;
      crystal_sel_out        <= 1'b0;
      pause_req_out          <= 1'b0;
      phase_lead_out         <= 1'b0;
      phase_lag_out          <= 1'b0;
      freq_ratio_out         <= 4'h0;
      mode_invalid_out       <= 1'b0;
    end else begin
      hrdata_out             <= rd_take ? rd_mux : 32'h00000000;
      hreadyout_out          <= 1'b1;
      hresp_out              <= 1'b0;
      clock_mode_out         <= mode;
      pll_a_run_out          <= a_run;
      pll_b_run_out          <= b_run;
      bidir_clock_pin_oe_out <= drive;
      ref_from_pin_out       <= plan.ref_from_pin;
      crystal_sel_out        <= ~plan.ref_from_pin & pause_req_or_crystal_sel_in;
      pause_req_out          <= plan.ref_from_pin & pause_req_or_crystal_sel_in;
      phase_lead_out         <= plan.quarter_lead & a_run;
      phase_lag_out          <= plan.quarter_lag & a_run;
      freq_ratio_out         <= freq;
      mode_invalid_out       <= ~plan.valid;
    end
  end

  a_mode_frozen: assert property (@(posedge clock_in) disable iff (rst_in)
    !rst_seen |-> mode == $past(mode)) else $error("mode changed after reset");
  a_lead_needs_pll: assert property (@(posedge clock_in) disable iff (rst_in)
    phase_lead_out |-> $past(mode) == 3'h1 && $past(!pll_a_halt))
    else $error("phase lead without first PLL");
  a_lag_mode: assert property (@(posedge clock_in) disable iff (rst_in)
    phase_lag_out |-> $past(mode) == 3'h5) else $error("lag outside mode 5");
  a_pin_input_hi: assert property (@(posedge clock_in) disable iff (rst_in || rst_seen)
    mode[2] |-> pin_hiz && pll_b_halt) else $error("pin or second PLL active in 4-6");
  a_mode3_hiz: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h3) |=> !bidir_clock_pin_oe_out) else $error("mode 3 drives pin");
  a_no_hiz_pll: assert property (@(posedge clock_in) disable iff (rst_in || rst_seen)
    (plan.pll_a_avail && !pll_a_halt && plan.pin_can_drive) |-> !pin_hiz)
    else $error("hiz while first PLL runs");
  a_mode6_nopll: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h6) |=> !pll_a_run_out && !pll_b_run_out) else $error("PLL runs in mode 6");
  a_pause_mux: assert property (@(posedge clock_in) disable iff (rst_in)
    pause_req_out |-> !crystal_sel_out && $past(mode[2])) else $error("pause pin misrouted");
  a_freq_write: assert property (@(posedge clock_in) disable iff (rst_in)
    wr_fmr && !rst_seen |=> freq == $past(hwdata_in[3:0])) else $error("freq not written");

  // Plan outputs follow the latched mode one cycle later
  a_mode_out_match: assert property (@(posedge clock_in) disable iff (rst_in)
    1'b1 |=> clock_mode_out == $past(mode))
    else $error("mode output differs from latch");

  a_invalid_flag: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h7) |=> mode_invalid_out)
    else $error("invalid mode not flagged");

  a_mode0_drive: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h0 && !pin_hiz) |=> bidir_clock_pin_oe_out)
    else $error("mode 0 pin not driven");

  a_mode0_pll_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h0 && !pll_a_halt) |=> pll_a_run_out)
    else $error("mode 0 first PLL idle");

  a_mode0_pll_b: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h0 && !pll_b_halt) |=> pll_b_run_out)
    else $error("mode 0 second PLL idle");

  a_halt_stops_a: assert property (@(posedge clock_in) disable iff (rst_in)
    pll_a_halt |=> !pll_a_run_out)
    else $error("first PLL runs while halted");

  a_halt_stops_b: assert property (@(posedge clock_in) disable iff (rst_in)
    pll_b_halt |=> !pll_b_run_out)
    else $error("second PLL runs while halted");

  a_mode1_lead: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h1 && !pll_a_halt) |=> phase_lead_out)
    else $error("mode 1 lead missing");

  a_mode1_no_lag: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h1) |=> !phase_lag_out)
    else $error("lag shown in mode 1");

  a_mode2_no_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h2) |=> !pll_a_run_out)
    else $error("first PLL runs in mode 2");

  a_mode2_b_run: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h2 && !pll_b_halt) |=> pll_b_run_out)
    else $error("mode 2 second PLL idle");

  a_mode2_drive: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h2 && !pin_hiz) |=> bidir_clock_pin_oe_out)
    else $error("mode 2 pin not driven");

  a_mode2_no_shift: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h2) |=> !phase_lead_out && !phase_lag_out)
    else $error("phase shift in mode 2");

  a_mode3_no_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h3) |=> !pll_a_run_out)
    else $error("first PLL runs in mode 3");

  a_mode3_b_run: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h3 && !pll_b_halt) |=> pll_b_run_out)
    else $error("mode 3 second PLL idle");

  a_hiz_mode3: assert property (@(posedge clock_in) disable iff (rst_in || rst_seen)
    (mode == 3'h3) |-> pin_hiz)
    else $error("mode 3 hiz bit clear");

  a_mode4_no_b: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h4) |=> !pll_b_run_out)
    else $error("second PLL runs in mode 4");

  a_mode4_a_run: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h4 && !pll_a_halt) |=> pll_a_run_out)
    else $error("mode 4 first PLL idle");

  a_mode4_no_shift: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h4) |=> !phase_lead_out && !phase_lag_out)
    else $error("phase shift in mode 4");

  a_mode5_lag: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h5 && !pll_a_halt) |=> phase_lag_out)
    else $error("mode 5 lag missing");

  a_mode5_no_lead: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h5) |=> !phase_lead_out)
    else $error("lead shown in mode 5");

  a_mode5_no_b: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h5) |=> !pll_b_run_out)
    else $error("second PLL runs in mode 5");

  a_mode6_pin_in: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h6) |=> ref_from_pin_out && !bidir_clock_pin_oe_out)
    else $error("mode 6 pin not an input");

  a_mode6_no_shift: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode == 3'h6) |=> !phase_lead_out && !phase_lag_out)
    else $error("phase shift in mode 6");

  a_osc_ref: assert property (@(posedge clock_in) disable iff (rst_in)
    !mode[2] |=> !ref_from_pin_out)
    else $error("pin reference in modes 0-3");

  a_pin_ref: assert property (@(posedge clock_in) disable iff (rst_in)
    mode[2] |=> ref_from_pin_out && !bidir_clock_pin_oe_out)
    else $error("pin driven in modes 4-6");

  a_pause_route: assert property (@(posedge clock_in) disable iff (rst_in)
    (mode[2] && pause_req_or_crystal_sel_in) |=> pause_req_out)
    else $error("pause request lost");

  a_crystal_route: assert property (@(posedge clock_in) disable iff (rst_in)
    (!mode[2] && pause_req_or_crystal_sel_in) |=> crystal_sel_out && !pause_req_out)
    else $error("crystal select lost");

  a_no_crystal: assert property (@(posedge clock_in) disable iff (rst_in)
    !pause_req_or_crystal_sel_in |=> !crystal_sel_out && !pause_req_out)
    else $error("dual pin routed while low");

  a_freq_out: assert property (@(posedge clock_in) disable iff (rst_in)
    1'b1 |=> freq_ratio_out == $past(freq))
    else $error("frequency output stale");

  a_a_unavail: assert property (@(posedge clock_in) disable iff (rst_in || rst_seen)
    (mode == 3'h2 || mode == 3'h3 || mode == 3'h6) |-> pll_a_halt)
    else $error("first PLL bit clear where unavailable");

  a_rsvd_zero: assert property (@(posedge clock_in) disable iff (rst_in)
    1'b1 |-> !hrdata_out[4])
    else $error("reserved bit read as one");

  a_bus_okay: assert property (@(posedge clock_in) disable iff (rst_in)
    1'b1 |-> hreadyout_out && !hresp_out)
    else $error("bus not ready or error");

endmodule
`default_nettype wire

// ---- verilog/cms_mode_decode.sv ----
// Decoder from a latched clock mode to its clock plan.
`timescale 1ns/1ps
`default_nettype none
module cms_mode_decode (
  // Mode in
  input  wire logic [2:0]        mode_in,
  // Plan out
  output var cms_pkg::cms_plan_s plan_out,
  output logic [7:0]             init_out
);

  wire logic m01 = (mode_in == cms_pkg::CMS_MODE0) | (mode_in == cms_pkg::CMS_MODE1);
  wire logic m45 = (mode_in == cms_pkg::CMS_MODE4) | (mode_in == cms_pkg::CMS_MODE5);
  wire logic lo  = ~mode_in[2];

  assign plan_out.valid         = (mode_in != cms_pkg::CMS_MODE7);
  assign plan_out.pll_a_avail   = m01 | m45;
  assign plan_out.pll_b_avail   = lo;
  assign plan_out.pin_can_drive = lo & (mode_in != cms_pkg::CMS_MODE3);
  assign plan_out.pin_is_input  = ~lo;
  assign plan_out.quarter_lead  = (mode_in == cms_pkg::CMS_MODE1);
  assign plan_out.quarter_lag   = (mode_in == cms_pkg::CMS_MODE5);
  assign plan_out.ref_from_pin  = ~lo;

  assign init_out = m01 ? cms_pkg::FMR_INIT_M01 :
                    (mode_in == cms_pkg::CMS_MODE2) ? cms_pkg::FMR_INIT_M2 :
                    (mode_in == cms_pkg::CMS_MODE3) ? cms_pkg::FMR_INIT_M3 :
                    m45 ? cms_pkg::FMR_INIT_M45 : cms_pkg::FMR_INIT_M6;

endmodule
`default_nettype wire

// ---- verilog/cms_pkg.sv ----
// Package with clock mode encodings, register layout and bus constants.
package cms_pkg;

  typedef enum logic [2:0] {
    CMS_MODE0 = 3'h0,
    CMS_MODE1 = 3'h1,
    CMS_MODE2 = 3'h2,
    CMS_MODE3 = 3'h3,
    CMS_MODE4 = 3'h4,
    CMS_MODE5 = 3'h5,
    CMS_MODE6 = 3'h6,
    CMS_MODE7 = 3'h7
  } cms_mode_e;

  // Register byte offsets
  localparam logic [7:0] FMR_OFFSET  = 8'h00;
  localparam logic [7:0] STAT_OFFSET = 8'h04;

  // Frequency setting register fields
  localparam int PLL_B_HALT_POS   = 7;
  localparam int PLL_A_HALT_POS   = 6;
  localparam int CLK_PIN_HIZ_POS  = 5;
  localparam int RSVD_POS         = 4;
  localparam int FR_LSB           = 0;
  localparam int FR_WIDTH         = 4;

  // Reset values per mode
  localparam logic [7:0] FMR_INIT_M01 = 8'h00;
  localparam logic [7:0] FMR_INIT_M2  = 8'h40;
  localparam logic [7:0] FMR_INIT_M3  = 8'h60;
  localparam logic [7:0] FMR_INIT_M45 = 8'hA6;
  localparam logic [7:0] FMR_INIT_M6  = 8'hE0;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // Decoded clock plan carried from decoder to main logic
  typedef struct packed {
    logic valid;
    logic pll_a_avail;
    logic pll_b_avail;
    logic pin_can_drive;
    logic pin_is_input;
    logic quarter_lead;
    logic quarter_lag;
    logic ref_from_pin;
  } cms_plan_s;

endpackage
